// ### dcsu_pkg.sv
package dcsu_pkg;
  // ----------------------------------------
  // port addresses
  // ----------------------------------------
  localparam logic [9:0] ADDR_DRIVE_OUTPUT_CONTROL = 10'h3f2;
  localparam logic [9:0] ADDR_MAIN_STATUS = 10'h3f4;
  localparam logic [9:0] ADDR_DATA_PORT = 10'h3f5;
  localparam logic [7:0] DOC_RESET_VALUE = 8'h00;
  // ----------------------------------------
  // drive output control fields
  // ----------------------------------------
  localparam int DOC_CORE_RUN_BIT = 2;
  localparam int DOC_REQ_GATE_BIT = 3;
  // ----------------------------------------
  // main status fields
  // ----------------------------------------
  localparam int MS_PORT_READY_BIT = 7;
  localparam int MS_DIRECTION_BIT = 6;
  localparam int MS_BUSY_BIT = 4;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_RECALIBRATE = 8'h07;
  localparam logic [7:0] OP_SENSE_INT = 8'h08;
  localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
  localparam logic [7:0] OP_SEEK = 8'h0f;
  localparam logic [7:0] INVALID_RESULT = 8'h80;
  // ----------------------------------------
  // termination codes
  // ----------------------------------------
  localparam logic [1:0] TC_NORMAL = 2'b00;
  localparam logic [1:0] TC_FAILED = 2'b01;
  localparam logic [1:0] TC_INVALID = 2'b10;
  localparam logic [1:0] TC_READY_CHANGED = 2'b11;
  localparam logic [7:0] BAD_CYLINDER_VALUE = 8'hff;
  localparam int RECAL_MAX_STEPS = 77;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_TIME_NS = 2000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MEDIA_WINDOW_NS = 4000;
  localparam int MEDIA_CYCLES = (MEDIA_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DCSU_IDLE,
    DCSU_PARAM,
    DCSU_STEP,
    DCSU_MEDIA,
    DCSU_RESULT
  } dcsu_state_e;
endpackage : dcsu_pkg

// ### dcsu_core.sv
// How it works
// RL1: status zero bits 7:6 hold the termination code of the command.
// RL2: seek_end in status zero bit 5 is set when a seek completes.
// RL3: equipment_check set on drive fault or no track zero after 77 steps.
// RL4: not_ready set for medium access to unready drive or side one single-sided.
// RL5: status zero bit 2 holds head, bits 1:0 the unit.
// RL6: end_of_cylinder in status one bit 7 on access past last sector.
// RL7: status one bits 6,3 and status two bit 7 always read zero.
// RL8: crc fault sets status one bit 5; data-field fault also status two bit 5.
// RL9: overrun in status one bit 4 when a data byte is not serviced in time.
// RL10: no_data in status one bit 2 when a sector or id cannot be found.
// RL11: not_writable in status one bit 1 on write protect during writes.
// RL12: missing id mark sets status one bit 0 and status two bit 0.
// RL13: control_mark in status two bit 6 on deleted data mark found.
// RL14: wrong_cylinder on medium cylinder mismatch; bad_cylinder when it is ff.
// RL15: scan equal sets status two bit 3; scan never satisfied sets bit 2.
// RL16: status three returns fault, protect, ready, track zero, sides, head, unit.
// RL17: undefined opcode does nothing and returns one byte 80 as status zero.
// RL18: recalibrate is opcode 07 plus unit byte, steps to track zero, no result.
// RL19: sense interrupt is opcode 08, returns status zero then present cylinder.
// RL20: sense drive is opcode 04 plus head and unit byte, returns status three.
// RL21: seek is opcode 0f, unit byte, new cylinder; steps there, no result.
// RL22: data port 3f5, main status 3f4, output control 3f2; channel reset clears it.
// RL23: main status bit 7 shows port ready, bit 6 the direction.
// RL24: core held reset while control bit 2 clear; requests gated by bit 3.
// RL25: interrupt raised at completion and held until results are read; seek and recalibrate drop it when the sense interrupt opcode is written.
// RL26: host reads all result bytes before sending the next opcode.
module dcsu_core #(
  parameter int CYL_W = 8
) (
  // clock and channel reset
  input wire logic clk,
  input wire logic reset_n,
  // host i/o channel
  input wire logic [9:0] io_addr,
  input wire logic io_addr_enable_n,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe,
  output logic irq,
  output logic irq_oe,
  // drive side
  input wire logic drive_fault,
  input wire logic drive_write_protect,
  input wire logic drive_ready,
  input wire logic at_track_zero,
  input wire logic two_sided,
  output logic [1:0] drive_unit,
  output logic head_number,
  output logic step_pulse,
  output logic step_inward,
  output logic [3:0] motor_enable,
  // medium event reports from the read datapath
  input wire logic media_end_cylinder,
  input wire logic media_crc_id,
  input wire logic media_crc_data,
  input wire logic media_overrun,
  input wire logic media_no_data,
  input wire logic media_missing_id,
  input wire logic media_missing_data,
  input wire logic media_deleted_mark,
  input wire logic [7:0] media_cylinder,
  input wire logic media_cyl_valid,
  input wire logic media_scan_equal,
  input wire logic media_scan_fail
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  dcsu_pkg::dcsu_state_e state_q, state_d;
  logic [7:0] doc_q, doc_d;
  logic [7:0] op_q, op_d;
  logic [1:0] pidx_q, pidx_d;
  logic [1:0] unit_q, unit_d;
  logic head_q, head_d;
  logic [CYL_W-1:0] pcn_q, pcn_d, ncn_q, ncn_d;
  logic [7:0] st0_q, st0_d, st1_q, st1_d, st2_q, st2_d;
  logic [7:0] res0_q, res0_d, res1_q, res1_d;
  logic [1:0] rcnt_q, rcnt_d, ridx_q, ridx_d;
  logic [15:0] tmr_q, tmr_d;
  logic [6:0] steps_q, steps_d;
  logic int_pend_q, int_pend_d;
  logic ready_seen_q, ready_seen_d;
  logic step_q, step_d;
  logic dir_q, dir_d;
  logic [7:0] rdata_q, rdata_d;
  logic rdoe_q, rdoe_d;
  logic irq_q, irq_d;
  logic irqoe_q, irqoe_d;

  logic core_run;
  logic sel_data, sel_status, sel_doc;
  logic [7:0] main_status;

  // status three from live drive lines and driven selections
  function automatic logic [7:0] drive_status(input logic [1:0] u, input logic h, ft, wp, ry, t0, ts);
    drive_status = {ft, wp, ry, t0, ts, h, u}; // [RL16]
  endfunction : drive_status

  // termination and unit fields are common to every status zero
  function automatic logic [7:0] st0_make(input logic [1:0] tc, input logic se, ec, nr, h, input logic [1:0] u);
    st0_make = {tc, se, ec, nr, h, u}; // [RL1] [RL5]
  endfunction : st0_make

  // ----------------------------------------
  // port decode
  // ----------------------------------------
  // address lines are ignored while a dma cycle owns the bus
  assign sel_data = !io_addr_enable_n && io_addr == dcsu_pkg::ADDR_DATA_PORT; // [RL22]
  assign sel_status = !io_addr_enable_n && io_addr == dcsu_pkg::ADDR_MAIN_STATUS; // [RL22]
  assign sel_doc = !io_addr_enable_n && io_addr == dcsu_pkg::ADDR_DRIVE_OUTPUT_CONTROL; // [RL22]
  assign core_run = doc_q[dcsu_pkg::DOC_CORE_RUN_BIT]; // [RL24]

  // port ready outside busy work; direction follows the result phase
  always_comb begin
    main_status = 8'h00;
    main_status[dcsu_pkg::MS_PORT_READY_BIT] = core_run &&
        (state_q == dcsu_pkg::DCSU_IDLE || state_q == dcsu_pkg::DCSU_PARAM ||
         state_q == dcsu_pkg::DCSU_RESULT); // [RL23]
    main_status[dcsu_pkg::MS_DIRECTION_BIT] = (state_q == dcsu_pkg::DCSU_RESULT); // [RL23]
    main_status[dcsu_pkg::MS_BUSY_BIT] = (state_q != dcsu_pkg::DCSU_IDLE);
    if (state_q == dcsu_pkg::DCSU_STEP) begin
      main_status[unit_q] = 1'b1;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    doc_d = doc_q;
    op_d = op_q;
    pidx_d = pidx_q;
    unit_d = unit_q;
    head_d = head_q;
    pcn_d = pcn_q;
    ncn_d = ncn_q;
    st0_d = st0_q;
    st1_d = st1_q;
    st2_d = st2_q;
    res0_d = res0_q;
    res1_d = res1_q;
    rcnt_d = rcnt_q;
    ridx_d = ridx_q;
    tmr_d = tmr_q;
    steps_d = steps_q;
    int_pend_d = int_pend_q;
    ready_seen_d = ready_seen_q;
    step_d = 1'b0;
    dir_d = dir_q;
    rdata_d = 8'h00;
    rdoe_d = 1'b0;
    if (io_write && sel_doc) begin
      doc_d = io_wdata;
    end
    if (io_read && sel_status) begin
      rdata_d = main_status;
      rdoe_d = 1'b1;
    end
    unique case (state_q)
      dcsu_pkg::DCSU_IDLE: begin
        if (io_write && sel_data) begin
          op_d = io_wdata;
          pidx_d = 2'd0;
          if (io_wdata == dcsu_pkg::OP_SENSE_INT) begin
            // sense interrupt reports the last seek and clears it
            res0_d = st0_q; // [RL19]
            res1_d = 8'(pcn_q); // [RL19]
            rcnt_d = 2'd2;
            ridx_d = 2'd0;
            if (!int_pend_q) begin
              res0_d = dcsu_pkg::INVALID_RESULT;
              rcnt_d = 2'd1;
            end
            int_pend_d = 1'b0;
            state_d = dcsu_pkg::DCSU_RESULT;
          end else if (io_wdata == dcsu_pkg::OP_RECALIBRATE || io_wdata == dcsu_pkg::OP_SEEK ||
                       io_wdata == dcsu_pkg::OP_SENSE_DRIVE) begin
            state_d = dcsu_pkg::DCSU_PARAM; // [RL18] [RL20] [RL21]
          end else if (io_wdata[4:0] == 5'h06 || io_wdata[4:0] == 5'h05) begin
            // medium read/write: parameters are taken by the datapath
            st1_d = 8'h00;
            st2_d = 8'h00;
            ready_seen_d = drive_ready;
            tmr_d = 16'(dcsu_pkg::MEDIA_CYCLES);
            state_d = dcsu_pkg::DCSU_MEDIA;
          end else begin
            res0_d = dcsu_pkg::INVALID_RESULT; // [RL17]
            rcnt_d = 2'd1;
            ridx_d = 2'd0;
            state_d = dcsu_pkg::DCSU_RESULT;
          end
        end
      end
      dcsu_pkg::DCSU_PARAM: begin
        if (io_write && sel_data) begin
          pidx_d = pidx_q + 2'd1;
          if (pidx_q == 2'd0) begin
            unit_d = io_wdata[1:0];
            head_d = (op_q == dcsu_pkg::OP_RECALIBRATE) ? 1'b0 : io_wdata[2];
            if (op_q == dcsu_pkg::OP_SENSE_DRIVE) begin
              res0_d = drive_status(io_wdata[1:0], io_wdata[2], drive_fault, drive_write_protect,
                                    drive_ready, at_track_zero, two_sided); // [RL20]
              rcnt_d = 2'd1;
              ridx_d = 2'd0;
              state_d = dcsu_pkg::DCSU_RESULT;
            end else if (op_q == dcsu_pkg::OP_RECALIBRATE) begin
              ncn_d = '0; // [RL18]
              steps_d = 7'd0;
              tmr_d = 16'd0;
              state_d = dcsu_pkg::DCSU_STEP;
            end
          end else begin
            ncn_d = io_wdata[CYL_W-1:0]; // [RL21]
            tmr_d = 16'd0;
            state_d = dcsu_pkg::DCSU_STEP;
          end
        end
      end
      dcsu_pkg::DCSU_STEP: begin
        // one step per step interval, no result phase afterwards
        if (tmr_q != 16'd0) begin
          tmr_d = tmr_q - 16'd1;
        end else if (drive_fault) begin
          st0_d = st0_make(dcsu_pkg::TC_FAILED, 1'b1, 1'b1, 1'b0, head_q, unit_q); // [RL3]
          int_pend_d = 1'b1; // [RL25]
          state_d = dcsu_pkg::DCSU_IDLE;
        end else if (op_q == dcsu_pkg::OP_RECALIBRATE) begin
          if (at_track_zero) begin
            pcn_d = '0;
            st0_d = st0_make(dcsu_pkg::TC_NORMAL, 1'b1, 1'b0, 1'b0, head_q, unit_q); // [RL2]
            int_pend_d = 1'b1;
            state_d = dcsu_pkg::DCSU_IDLE;
          end else if (steps_q == 7'(dcsu_pkg::RECAL_MAX_STEPS)) begin
            st0_d = st0_make(dcsu_pkg::TC_FAILED, 1'b1, 1'b1, 1'b0, head_q, unit_q); // [RL3]
            int_pend_d = 1'b1;
            state_d = dcsu_pkg::DCSU_IDLE;
          end else begin
            steps_d = steps_q + 7'd1;
            step_d = 1'b1;
            dir_d = 1'b0;
            tmr_d = 16'(dcsu_pkg::STEP_CYCLES);
          end
        end else if (pcn_q == ncn_q) begin
          st0_d = st0_make(dcsu_pkg::TC_NORMAL, 1'b1, 1'b0, 1'b0, head_q, unit_q); // [RL2]
          int_pend_d = 1'b1;
          state_d = dcsu_pkg::DCSU_IDLE;
        end else begin
          step_d = 1'b1;
          dir_d = ncn_q > pcn_q;
          pcn_d = (ncn_q > pcn_q) ? pcn_q + 1'b1 : pcn_q - 1'b1;
          tmr_d = 16'(dcsu_pkg::STEP_CYCLES);
        end
      end
      dcsu_pkg::DCSU_MEDIA: begin
        // gather medium reports until the window closes
        st1_d[7] = st1_q[7] | media_end_cylinder; // [RL6]
        st1_d[5] = st1_q[5] | media_crc_id | media_crc_data; // [RL8]
        st2_d[5] = st2_q[5] | media_crc_data; // [RL8]
        st1_d[4] = st1_q[4] | media_overrun; // [RL9]
        st1_d[2] = st1_q[2] | media_no_data; // [RL10]
        st1_d[1] = st1_q[1] | (drive_write_protect && op_q[4:0] == 5'h05); // [RL11]
        st1_d[0] = st1_q[0] | media_missing_id; // [RL12]
        st2_d[0] = st2_q[0] | media_missing_id | media_missing_data; // [RL12]
        st2_d[6] = st2_q[6] | media_deleted_mark; // [RL13]
        if (media_cyl_valid && media_cylinder != 8'(pcn_q)) begin
          st2_d[4] = 1'b1; // [RL14]
          st2_d[1] = st2_q[1] | (media_cylinder == dcsu_pkg::BAD_CYLINDER_VALUE); // [RL14]
        end
        st2_d[3] = st2_q[3] | media_scan_equal; // [RL15]
        st2_d[2] = st2_q[2] | media_scan_fail; // [RL15]
        st1_d[6] = 1'b0; // [RL7]
        st1_d[3] = 1'b0; // [RL7]
        st2_d[7] = 1'b0; // [RL7]
        tmr_d = tmr_q - 16'd1;
        if (!drive_ready || (head_q && !two_sided) || tmr_q == 16'd0 || drive_ready != ready_seen_q) begin
          if (drive_ready != ready_seen_q) begin
            res0_d = st0_make(dcsu_pkg::TC_READY_CHANGED, 1'b0, drive_fault, 1'b0, head_q, unit_q);
          end else if (!drive_ready || (head_q && !two_sided)) begin
            res0_d = st0_make(dcsu_pkg::TC_FAILED, 1'b0, drive_fault, 1'b1, head_q, unit_q); // [RL4]
          end else if (drive_fault || st1_d != 8'h00 || (st2_d & 8'h37) != 8'h00) begin
            res0_d = st0_make(dcsu_pkg::TC_FAILED, 1'b0, drive_fault, 1'b0, head_q, unit_q); // [RL3]
          end else begin
            res0_d = st0_make(dcsu_pkg::TC_NORMAL, 1'b0, 1'b0, 1'b0, head_q, unit_q);
          end
          res1_d = st1_d;
          rcnt_d = 2'd3;
          ridx_d = 2'd0;
          state_d = dcsu_pkg::DCSU_RESULT;
        end
      end
      dcsu_pkg::DCSU_RESULT: begin
        // stays here until the last byte is read by the host
        if (io_read && sel_data) begin
          rdoe_d = 1'b1;
          rdata_d = (ridx_q == 2'd0) ? res0_q : (ridx_q == 2'd1) ? res1_q : st2_q; // [RL26]
          ridx_d = ridx_q + 2'd1;
          if (ridx_q + 2'd1 == rcnt_q) begin
            state_d = dcsu_pkg::DCSU_IDLE;
          end
        end
      end
    endcase
    // while the core is held reset, its state returns to idle
    if (!core_run) begin
      state_d = dcsu_pkg::DCSU_IDLE; // [RL24]
      int_pend_d = 1'b0;
      pcn_d = '0;
      st0_d = 8'h00;
    end
  end

  // interrupt stays up from a medium completion through its result reads, and from a seek or recalibrate until a sense interrupt opcode
  always_comb begin
    irq_d = int_pend_d || (state_d == dcsu_pkg::DCSU_RESULT && op_d[4:0] != 5'h08 &&
            rcnt_d == 2'd3); // [RL25]
    irqoe_d = doc_d[dcsu_pkg::DOC_REQ_GATE_BIT]; // [RL24]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= dcsu_pkg::DCSU_IDLE;
      doc_q <= dcsu_pkg::DOC_RESET_VALUE; // [RL22]
      op_q <= 8'h00;
      pidx_q <= 2'd0;
      unit_q <= 2'd0;
      head_q <= 1'b0;
      pcn_q <= '0;
      ncn_q <= '0;
      st0_q <= 8'h00;
      st1_q <= 8'h00;
      st2_q <= 8'h00;
      res0_q <= 8'h00;
      res1_q <= 8'h00;
      rcnt_q <= 2'd0;
      ridx_q <= 2'd0;
      tmr_q <= 16'd0;
      steps_q <= 7'd0;
      int_pend_q <= 1'b0;
      ready_seen_q <= 1'b0;
      step_q <= 1'b0;
      dir_q <= 1'b0;
      rdata_q <= 8'h00;
      rdoe_q <= 1'b0;
      irq_q <= 1'b0;
      irqoe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      doc_q <= doc_d;
      op_q <= op_d;
      pidx_q <= pidx_d;
      unit_q <= unit_d;
      head_q <= head_d;
      pcn_q <= pcn_d;
      ncn_q <= ncn_d;
      st0_q <= st0_d;
      st1_q <= st1_d;
      st2_q <= st2_d;
      res0_q <= res0_d;
      res1_q <= res1_d;
      rcnt_q <= rcnt_d;
      ridx_q <= ridx_d;
      tmr_q <= tmr_d;
      steps_q <= steps_d;
      int_pend_q <= int_pend_d;
      ready_seen_q <= ready_seen_d;
      step_q <= step_d;
      dir_q <= dir_d;
      rdata_q <= rdata_d;
      rdoe_q <= rdoe_d;
      irq_q <= irq_d;
      irqoe_q <= irqoe_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign io_rdata = rdata_q;
  assign io_rdata_oe = rdoe_q;
  assign irq = irq_q;
  assign irq_oe = irqoe_q;
  assign drive_unit = unit_q;
  assign head_number = head_q;
  assign step_pulse = step_q;
  assign step_inward = dir_q;
  assign motor_enable = doc_q[7:4];
endmodule : dcsu_core

// ### dcsu_core_asserts.sv
module dcsu_core_asserts (
  // clock and channel reset
  input wire logic clk,
  input wire logic reset_n,
  // host channel
  input wire logic [9:0] io_addr,
  input wire logic io_addr_enable_n,
  input wire logic io_read,
  input wire logic io_write,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_oe,
  input wire logic irq,
  input wire logic irq_oe,
  // drive side
  input wire logic step_pulse,
  input wire logic [3:0] motor_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // helper decode
  // ----------------
  logic doc_wr, rd_hit;
  logic [7:0] doc_q;
  // decoded channel cycles
  assign doc_wr = io_write && !io_addr_enable_n && io_addr == dcsu_pkg::ADDR_DRIVE_OUTPUT_CONTROL;
  assign rd_hit = io_read && !io_addr_enable_n &&
    (io_addr == dcsu_pkg::ADDR_MAIN_STATUS || io_addr == dcsu_pkg::ADDR_DATA_PORT);
  // shadow of the control port, so outputs can be tied to the last write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) doc_q <= dcsu_pkg::DOC_RESET_VALUE;
    else if (doc_wr) doc_q <= io_wdata;
  end
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  oe_cause_a: assert property (io_rdata_oe |-> $past(rd_hit))
    else $error("read data without a read");
  idle_data_zero_a: assert property (!io_rdata_oe |-> io_rdata == 8'h00)
    else $error("idle read data not zero");
  motor_follow_a: assert property (motor_enable == doc_q[7:4])
    else $error("motor enables wrong");
  gate_follow_a: assert property (irq_oe == doc_q[dcsu_pkg::DOC_REQ_GATE_BIT])
    else $error("request gate wrong");
  irq_quiet_a: assert property (!doc_q[2] && $stable(doc_q) |-> !irq)
    else $error("irq while core held");
  irq_rise_a: assert property ($rose(irq) |-> doc_q[dcsu_pkg::DOC_CORE_RUN_BIT])
    else $error("irq rose, core held");
  step_gap_a: assert property (step_pulse |=> (!step_pulse) [*8])
    else $error("step pulses too close");
  reset_clear_a: assert property ($rose(reset_n) |-> !irq && !step_pulse && motor_enable == 4'h0)
    else $error("outputs set after reset");
  // main scenarios reached
  step_c: cover property (step_pulse);
  irq_c: cover property ($rose(irq));
  invalid_c: cover property (io_rdata_oe && io_rdata == dcsu_pkg::INVALID_RESULT);
endmodule : dcsu_core_asserts

// ### dcsu_host_model.sv
module dcsu_host_model (
  // clock
  input wire logic clk,
  // channel cycle
  output logic [9:0] io_addr,
  output logic io_addr_enable_n,
  output logic io_read,
  output logic io_write,
  output logic [7:0] io_wdata,
  // returned data
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // channel cycles
  // ----------------
  // idle bus from time zero
  initial begin
    io_addr = 10'h000;
    io_addr_enable_n = 1'b1;
    io_read = 1'b0;
    io_write = 1'b0;
    io_wdata = 8'h00;
  end
  // one read; released lines flip, never stale
  task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_addr_enable_n <= 1'b0;
    io_read <= 1'b1;
    @(posedge clk);
    io_read <= 1'b0;
    io_addr_enable_n <= 1'b1;
    io_addr <= ~a;
    #1 d = io_rdata;
  endtask : bus_rd
  // one write
  task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_addr_enable_n <= 1'b0;
    io_wdata <= d;
    io_write <= 1'b1;
    @(posedge clk);
    io_write <= 1'b0;
    io_addr_enable_n <= 1'b1;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask : bus_wr
  // poll until the port is ready in the wanted direction
  task automatic wait_port(input logic dir);
    logic [7:0] s;
    int k;
    for (k = 0; k < 4000; k++) begin
      bus_rd(dcsu_pkg::ADDR_MAIN_STATUS, s);
      if (s[7] === 1'b1 && s[6] === dir) break;
    end
  endtask : wait_port
  // data port byte each way, after the handshake agrees or 4000 polls pass
  task automatic wr_data(input logic [7:0] b);
    wait_port(1'b0);
    bus_wr(dcsu_pkg::ADDR_DATA_PORT, b);
  endtask : wr_data
  task automatic rd_data(output logic [7:0] b);
    wait_port(1'b1);
    bus_rd(dcsu_pkg::ADDR_DATA_PORT, b);
  endtask : rd_data
endmodule : dcsu_host_model

// ### dcsu_core_bench.sv
module dcsu_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // signals and parts
  // ----------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] io_addr;
  logic io_addr_enable_n, io_read, io_write, io_rdata_oe, irq, irq_oe;
  logic [7:0] io_wdata, io_rdata;
  logic [1:0] drive_unit;
  logic head_number, step_pulse, step_inward;
  logic [3:0] motor_enable;
  logic flt = 1'b0, wp = 1'b0, ry = 1'b1, ts = 1'b0, t0_stuck = 1'b0;
  logic [10:0] ev = 11'h000;
  int cyl = 0, steps = 0, seed = 32'h490b, mismatches = 0, tests_run = 0;
  dcsu_core dut_u (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_addr_enable_n(io_addr_enable_n),
    .io_read(io_read), .io_write(io_write), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
    .irq(irq), .irq_oe(irq_oe), .drive_fault(flt), .drive_write_protect(wp), .drive_ready(ry),
    .at_track_zero(cyl == 0 && !t0_stuck), .two_sided(ts), .drive_unit(drive_unit), .head_number(head_number),
    .step_pulse(step_pulse), .step_inward(step_inward), .motor_enable(motor_enable),
    .media_end_cylinder(ev[0]), .media_crc_id(ev[1]), .media_crc_data(ev[2]), .media_overrun(ev[3]),
    .media_no_data(ev[4]), .media_missing_id(ev[5]), .media_missing_data(ev[6]), .media_deleted_mark(ev[7]),
    .media_cylinder({8{ev[8]}}), .media_cyl_valid(ev[8]), .media_scan_equal(ev[9]), .media_scan_fail(ev[10]));
  dcsu_host_model host_u (.clk(clk), .io_addr(io_addr), .io_addr_enable_n(io_addr_enable_n),
    .io_read(io_read), .io_write(io_write), .io_wdata(io_wdata), .io_rdata(io_rdata));
  always #4 clk = ~clk;
  // head position of the drive, moved by each step
  always @(posedge clk) begin
    if (step_pulse === 1'b1) begin
      steps <= steps + 1;
      cyl <= step_inward ? cyl + 1 : cyl - 1;
    end
  end
  // ----------------
  // helpers
  // ----------------
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wait_irq(input int lim);
    int k;
    for (k = 0; k < lim && irq !== 1'b1; k++) @(negedge clk);
  endtask : wait_irq
  task automatic sense(output logic [7:0] st0, present_cylinder);
    host_u.wr_data(dcsu_pkg::OP_SENSE_INT);
    host_u.rd_data(st0);
    host_u.rd_data(present_cylinder);
  endtask : sense
  // codes near a defined command stay out of the invalid set
  function automatic logic is_cmd(input logic [7:0] op);
    return op[4:0] inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0f};
  endfunction : is_cmd
  // expected status one and two from medium events
  function automatic logic [15:0] exp_med(input logic [10:0] m, input logic nw);
    return {m[0], 1'b0, m[1] | m[2], m[3], 1'b0, m[4], nw, m[5],
      1'b0, m[7], m[2], m[8], m[9], m[10], m[8], m[5] | m[6]};
  endfunction : exp_med
  // ----------------
  // scenarios
  // ----------------
  initial begin
    logic [7:0] s, r, op;
    logic [10:0] m;
    logic [15:0] e;
    logic [1:0] u;
    int n, base, i, k;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 check("motor", {4'h0, motor_enable}, 8'h00);
    host_u.bus_wr(dcsu_pkg::ADDR_DRIVE_OUTPUT_CONTROL, 8'h1c);
    #1 check("motor on", {4'h0, motor_enable}, 8'h01);
    check("gate", {7'h00, irq_oe}, 8'h01);
    host_u.bus_rd(dcsu_pkg::ADDR_MAIN_STATUS, s);
    check("main status", s & 8'hc0, 8'h80);
    // undefined codes, and sense interrupt with nothing pending
    for (i = 0; i < 6; i++) begin
      op = (i == 0) ? 8'h00 : (i == 1) ? dcsu_pkg::OP_SENSE_INT : (i == 2) ? 8'hff : 8'($random(seed));
      while (i > 1 && is_cmd(op)) op = 8'($random(seed));
      host_u.wr_data(op);
      host_u.rd_data(r);
      check("invalid", r, dcsu_pkg::INVALID_RESULT);
    end
    // seek inward, then collect its status
    u = 2'($random(seed));
    n = 2 + ($random(seed) & 3);
    base = steps;
    host_u.wr_data(dcsu_pkg::OP_SEEK);
    host_u.wr_data({5'h01, u});
    host_u.wr_data(8'(n));
    wait_irq(n * 400);
    check("seek steps", 8'(steps - base), 8'(n));
    check("seek irq", {7'h00, irq}, 8'h01);
    check("unit", {6'h00, drive_unit}, {6'h00, u});
    check("head", {7'h00, head_number}, 8'h01);
    sense(r, s);
    check("seek st0", r, 8'h20 | {5'h01, u});
    check("pcn", s, 8'(n));
    #1 check("irq clear", {7'h00, irq}, 8'h00);
    // live drive levels
    @(posedge clk);
    {flt, wp, ry, ts} <= 4'($random(seed));
    host_u.wr_data(dcsu_pkg::OP_SENSE_DRIVE);
    host_u.wr_data({5'h01, u});
    host_u.rd_data(r);
    check("drive status", r, {flt, wp, ry, 1'b0, ts, 1'b1, u});
    @(posedge clk);
    {flt, wp, ry, ts} <= 4'b0010;
    // recalibrate that finds track zero, then one that never does
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      t0_stuck <= (i == 1);
      base = steps;
      n = cyl;
      host_u.wr_data(dcsu_pkg::OP_RECALIBRATE);
      host_u.wr_data({6'h00, u});
      wait_irq(26000);
      sense(r, s);
      if (i == 0) begin
        check("recal steps", 8'(steps - base), 8'(n));
        check("recal st0", r & 8'hd3, {6'h00, u});
        check("recal pcn", s, 8'h00);
      end else begin
        check("recal limit", 8'(steps - base), 8'(dcsu_pkg::RECAL_MAX_STEPS));
        check("recal fail st0", r & 8'hd0, 8'h50);
      end
    end
    // medium reads and a write, with events reported during the first two reads
    for (i = 0; i < 4; i++) begin
      m = (i == 0) ? 11'($random(seed)) : (i == 1) ? 11'h7ff : 11'h000;
      @(posedge clk);
      wp <= (i == 2);
      ry <= (i != 3);
      host_u.wr_data((i == 2) ? 8'h45 : 8'h46);
      for (k = 0; k < 3000; k++) begin
        host_u.bus_rd(dcsu_pkg::ADDR_MAIN_STATUS, s);
        if (s[7:6] === 2'b11) break;
        if (m != 11'h000) begin
          @(posedge clk);
          ev <= m;
          @(posedge clk);
          ev <= 9'h000;
        end
      end
      e = exp_med(m, i == 2);
      host_u.rd_data(r);
      check("medium st0", r & 8'h0b, {4'h0, i == 3, 1'b0, u});
      host_u.rd_data(s);
      if (i != 3) check("medium st1", s, e[15:8]);
      host_u.rd_data(r);
      if (i != 3) check("medium st2", r, e[7:0]);
    end
    // core held in reset ignores a command
    host_u.bus_wr(dcsu_pkg::ADDR_DRIVE_OUTPUT_CONTROL, 8'h08);
    host_u.bus_wr(dcsu_pkg::ADDR_DATA_PORT, 8'h1f);
    host_u.bus_rd(dcsu_pkg::ADDR_DATA_PORT, r);
    check("held core", r, 8'h00);
    end_of_test;
  end
  // hang guard, well past the longest recalibrate
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
endmodule : dcsu_core_bench
bind dcsu_core dcsu_core_asserts chk_u (.clk(clk), .reset_n(reset_n), .io_addr(io_addr),
  .io_addr_enable_n(io_addr_enable_n), .io_read(io_read), .io_write(io_write), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .irq(irq), .irq_oe(irq_oe), .step_pulse(step_pulse),
  .motor_enable(motor_enable));
